// ---- hdl/idc_code_reg.sv ----
// Purpose: I2C slave holding the converter code register
// Assumes: Open-drain SDA, SCL input only, power-on reset on rst_b
// Notes:   Code and power-down outputs feed the analog section
// What this block does
// - Code field is unsigned 0..1023, selecting one of 1024 taps.
// - Reset clears the register; output stays zero until a full write.
// - Writes to the broadcast address are accepted like own-address writes.
// - Broadcast power-down code powers down every converter together.
// - SDA driven only during our acknowledge or a read data byte.
// - Both lines ignore pulses under 50 ns, or 10 ns in high speed.
// - On the last bit of the second byte, before its acknowledge, update output; accept further pairs.
// - Read returns upper then lower byte; master acks first, nacks second.
// - Either power-down bit set enters power-down, register kept.
`timescale 1ns/1ps
`include "idc_defs.svh"
module idc_code_reg
  import idc_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = `IDC_OWN_ADDR_DEF
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Converter side
  output logic [9:0]      dac_code,
  output logic [1:0]      pd_mode,
  output logic            out_valid,
  output logic            hs_active
);
  idc_line_if ln ();
  idc_glitch_filter #(.CW(4)) u_filt (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .ln     (ln.filt)
  );
  idc_state_t  st_q, st_d;
  logic [7:0]  sh_q;
  logic [2:0]  bit_q;
  logic        rd_q;
  logic        hi_q;
  logic [15:0] reg_q;
  logic [7:0]  hib_q;
  logic        valid_q;
  logic        hs_q;
  logic        hsc_q;
  logic        oe_q;
  logic [9:0]  code_q;
  logic [1:0]  pd_q;
  logic        ack_rise_q;

  wire        byte_done = ln.scl_rise && bit_q == 3'h7;
  wire [7:0]  rx_byte   = {sh_q[6:0], ln.sda};
  wire        own_hit   = rx_byte[7:1] == OWN_ADDR;
  wire        bc_hit    = rx_byte[7:1] == `IDC_BCAST_ADDR;
  wire        hs_code   = rx_byte[7:3] == `IDC_HS_CODE_TOP;
  wire        addr_ok   = own_hit || (bc_hit && !rx_byte[0]);
  wire        ack_end   = ln.scl_fall && ack_rise_q;
  wire [15:0] wr_word   = {hib_q, rx_byte};

  // Next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      IDC_IDLE: st_d = IDC_IDLE;
      IDC_ADDR: if (byte_done) st_d = addr_ok ? IDC_AACK : IDC_SKIP;
      IDC_AACK: if (ack_end) st_d = rd_q ? IDC_RDAT : IDC_WDAT;
      IDC_WDAT: if (byte_done) st_d = IDC_WACK;
      IDC_WACK: if (ack_end) st_d = IDC_WDAT;
      IDC_RDAT: if (byte_done) st_d = IDC_RACK;
      IDC_RACK: if (ln.scl_rise) st_d = ln.sda ? IDC_SKIP : IDC_RDAT;
      IDC_SKIP: st_d = IDC_SKIP;
      default:  st_d = IDC_IDLE;
    endcase
    if (ln.stop)  st_d = IDC_IDLE;
    if (ln.start) st_d = IDC_ADDR;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) st_q <= IDC_IDLE;
    else        st_q <= st_d;
  end

  // Bit counter and shifter
  always_ff @(posedge mclk) begin
    if (!rst_b || ln.start || (st_q == IDC_AACK || st_q == IDC_WACK) && ack_end) begin
      bit_q <= 3'h0;
    end else if (st_q == IDC_RACK && ln.scl_rise) begin
      bit_q <= 3'h0;
    end else if (ln.scl_rise && st_q != IDC_IDLE && st_q != IDC_SKIP) begin
      bit_q <= bit_q + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) sh_q <= 8'h00;
    else if (ln.scl_rise) sh_q <= rx_byte;
  end

  // Ack slot ends on the first fall after its own rise
  always_ff @(posedge mclk) begin
    if (!rst_b || (st_q != IDC_AACK && st_q != IDC_WACK)) ack_rise_q <= 1'b0;
    else if (ln.scl_rise)                                  ack_rise_q <= 1'b1;
  end

  // Direction, byte phase, write register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rd_q    <= 1'b0;
      hi_q    <= 1'b1;
      hib_q   <= 8'h00;
      reg_q   <= `IDC_REG_RESET;
      valid_q <= 1'b0;
    end else begin
      if (st_q == IDC_ADDR && byte_done) begin
        rd_q <= rx_byte[0];
        hi_q <= 1'b1;
      end
      if (st_q == IDC_WDAT && byte_done) begin
        hi_q <= ~hi_q;
        if (hi_q) begin
          hib_q <= rx_byte;
        end else begin
          reg_q   <= wr_word;
          valid_q <= 1'b1;
        end
      end
      if (st_q == IDC_RACK && ln.scl_rise) hi_q <= ~hi_q;
    end
  end

  // High-speed mode: master code seen, held until stop
  always_ff @(posedge mclk) begin
    if (!rst_b || ln.stop) begin
      hs_q  <= 1'b0;
      hsc_q <= 1'b0;
    end else begin
      if (st_q == IDC_ADDR && byte_done) hsc_q <= hs_code;
      if (ln.start && hsc_q) hs_q <= 1'b1;
    end
  end
  assign ln.hs_mode = hs_q;

  // SDA drive: update after SCL low so setup holds for the master
  wire rd_bit = hi_q ? reg_q[15 - 32'(bit_q)] : reg_q[7 - 32'(bit_q)];
  wire drv_ack = st_q == IDC_AACK || st_q == IDC_WACK;
  wire drv_rd  = st_q == IDC_RDAT && !rd_bit;
  // Last read bit stays driven while SCL is high, else a false stop
  wire hold_rd = st_q == IDC_RDAT || st_q == IDC_RACK;
  always_ff @(posedge mclk) begin
    if (!rst_b) oe_q <= 1'b0;
    else        oe_q <= !ln.scl_rise && !ln.scl && (drv_ack || drv_rd) ||
                        ln.scl && oe_q && (drv_ack || hold_rd);
  end
  assign sda_out = 1'b0;
  assign sda_oe  = oe_q;

  // Converter outputs: zero code until first complete write
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      code_q <= 10'h000;
      pd_q   <= 2'h0;
    end else if (valid_q) begin
      code_q <= reg_q[`IDC_CODE_MSB:`IDC_CODE_LSB];
      pd_q   <= {reg_q[`IDC_PD_HI_BIT], reg_q[`IDC_PD_LO_BIT]};
    end
  end
  assign dac_code  = code_q;
  assign pd_mode   = pd_q;
  assign out_valid = valid_q;
  assign hs_active = hs_q;

  // Assertions
  property p_reset_clear;
    @(posedge mclk) !rst_b |=> reg_q == 16'h0000 && code_q == 10'h000 && !valid_q;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left data");

  property p_sda_only_owned;
    @(posedge mclk) disable iff (!rst_b)
      sda_oe |-> $past(st_q) inside {IDC_AACK, IDC_WACK, IDC_RDAT, IDC_RACK};
  endproperty
  a_sda_only_owned: assert property (p_sda_only_owned) else $error("sda driven");

  property p_pair_update;
    @(posedge mclk) disable iff (!rst_b)
      st_q == IDC_WDAT && byte_done && !hi_q |=> reg_q == $past(wr_word) ##1 valid_q;
  endproperty
  a_pair_update: assert property (p_pair_update) else $error("no update");

  property p_foreign_ignored;
    @(posedge mclk) disable iff (!rst_b)
      st_q == IDC_SKIP && !ln.start |=> $stable(reg_q);
  endproperty
  a_foreign_ignored: assert property (p_foreign_ignored) else $error("foreign write");

  property p_bcast_ack;
    @(posedge mclk) disable iff (!rst_b)
      st_q == IDC_ADDR && byte_done && bc_hit && !rx_byte[0] && !ln.start |=> st_q == IDC_AACK;
  endproperty
  a_bcast_ack: assert property (p_bcast_ack) else $error("broadcast refused");

  property p_pd_follows;
    @(posedge mclk) disable iff (!rst_b)
      valid_q |=> pd_q == {$past(reg_q[13]), $past(reg_q[12])};
  endproperty
  a_pd_follows: assert property (p_pd_follows) else $error("power-down lag");

  property p_code_range;
    @(posedge mclk) disable iff (!rst_b) valid_q |=> code_q == $past(reg_q[11:2]);
  endproperty
  a_code_range: assert property (p_code_range) else $error("code mismatch");

  property p_nack_ends_read;
    @(posedge mclk) disable iff (!rst_b)
      st_q == IDC_RACK && ln.scl_rise && ln.sda && !ln.start && !ln.stop |=> st_q == IDC_SKIP;
  endproperty
  a_nack_ends_read: assert property (p_nack_ends_read) else $error("nack ignored");

  c_write: cover property (@(posedge mclk) st_q == IDC_WACK && !hi_q);
  c_read:  cover property (@(posedge mclk) st_q == IDC_RACK);
  c_pd:    cover property (@(posedge mclk) pd_q != 2'h0);
  c_hs:    cover property (@(posedge mclk) hs_q);
endmodule // idc_code_reg

// ---- hdl/idc_defs.svh ----
// Purpose: Constants for the I2C converter code register block
// Assumes: 100 MHz mclk
// Notes:   Bit offsets, addresses, codes, reset value and timing counts
`ifndef IDC_DEFS_SVH
`define IDC_DEFS_SVH
`define IDC_CLK_PERIOD_NS   10
`define IDC_SPIKE_FS_NS     50
`define IDC_SPIKE_HS_NS     10
`define IDC_SPIKE_FS_CYC    ((`IDC_SPIKE_FS_NS / `IDC_CLK_PERIOD_NS) + 1)
`define IDC_SPIKE_HS_CYC    ((`IDC_SPIKE_HS_NS / `IDC_CLK_PERIOD_NS) + 1)
`define IDC_BCAST_ADDR      7'h48
`define IDC_OWN_ADDR_DEF    7'h0c
`define IDC_HS_CODE_TOP     5'h01
`define IDC_REG_RESET       16'h0000
`define IDC_PD_HI_BIT       13
`define IDC_PD_LO_BIT       12
`define IDC_CODE_MSB        11
`define IDC_CODE_LSB        2
`endif

// ---- hdl/idc_pkg.sv ----
// Purpose: Types for the I2C converter code register block
// Assumes: Nothing
// Notes:   States Gray coded along the usual path
package idc_pkg;
  typedef enum logic [2:0] {
    IDC_IDLE = 3'h0,
    IDC_ADDR = 3'h1,
    IDC_AACK = 3'h3,
    IDC_WDAT = 3'h2,
    IDC_WACK = 3'h6,
    IDC_RDAT = 3'h7,
    IDC_RACK = 3'h5,
    IDC_SKIP = 3'h4
  } idc_state_t;
  typedef enum logic [1:0] {
    IDC_PD_ON   = 2'h0,
    IDC_PD_2K5  = 2'h1,
    IDC_PD_100K = 2'h2,
    IDC_PD_HIZ  = 2'h3
  } idc_pd_t;
endpackage

// ---- hdl/idc_line_if.sv ----
// Purpose: Filtered bus lines and their events
// Assumes: All signals on mclk
// Notes:   Filter drives line events, slave core reads them and drives hs_mode
`timescale 1ns/1ps
interface idc_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic hs_mode;
  modport filt (output scl, sda, scl_rise, scl_fall, start, stop, input hs_mode);
  modport core (input scl, sda, scl_rise, scl_fall, start, stop, output hs_mode);
endinterface

// ---- hdl/idc_glitch_filter.sv ----
// Purpose: Synchronise and spike-filter SCL and SDA, detect bus events
// Assumes: Lines are asynchronous to mclk
// Notes:   Filter length follows the speed mode
`timescale 1ns/1ps
`include "idc_defs.svh"
module idc_glitch_filter
  import idc_pkg::*;
#(
  parameter int CW = 4
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // Pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  // Filtered side
  idc_line_if.filt  ln
);
  localparam logic [CW-1:0] FS_LEN = CW'(`IDC_SPIKE_FS_CYC);
  localparam logic [CW-1:0] HS_LEN = CW'(`IDC_SPIKE_HS_CYC);
  logic [1:0]    s1_q;
  logic [1:0]    s2_q;
  logic          flt_q [2];
  logic [1:0]    prv_q;
  logic [CW-1:0] cnt_q [2];
  wire  [CW-1:0] len = ln.hs_mode ? HS_LEN : FS_LEN;
  always_ff @(posedge mclk) begin
    s1_q <= {sda_in, scl_in};
    s2_q <= s1_q;
  end
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      // Level must hold for the spike length before it is accepted
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          cnt_q[g] <= '0;
          flt_q[g] <= 1'b1;
        end else if (s2_q[g] == flt_q[g]) begin
          cnt_q[g] <= '0;
        end else if (cnt_q[g] + CW'(1) >= len) begin
          cnt_q[g] <= '0;
          flt_q[g] <= s2_q[g];
        end else begin
          cnt_q[g] <= cnt_q[g] + CW'(1);
        end
      end
    end
  endgenerate
  always_ff @(posedge mclk) begin
    if (!rst_b) prv_q <= 2'h3;
    else        prv_q <= {flt_q[1], flt_q[0]};
  end
  assign ln.scl      = flt_q[0];
  assign ln.sda      = flt_q[1];
  assign ln.scl_rise = flt_q[0] & ~prv_q[0];
  assign ln.scl_fall = ~flt_q[0] & prv_q[0];
  assign ln.start    = flt_q[0] & prv_q[0] & prv_q[1] & ~flt_q[1];
  assign ln.stop     = flt_q[0] & prv_q[0] & ~prv_q[1] & flt_q[1];
endmodule // idc_glitch_filter

// ---- tb/idc_mst.sv ----
// Purpose: I2C master model for the converter code register
// Assumes: Open-drain lines with pull-ups, drives at mclk falling edge
// Notes:   drv marks slots that the master owns
`timescale 1ns/1ps
module idc_mst #(
  parameter int H = 16
) (
  // Clock
  input  wire logic mclk,
  // Bus
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low,
  output logic      drv
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
    drv     = 1'b1;
  end
  task automatic hc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Start or repeated start
  task automatic st();
    sda_low = 1'b0;
    hc(H);
    scl = 1'b1;
    hc(H);
    sda_low = 1'b1;
    hc(H);
    scl = 1'b0;
  endtask
  task automatic sp();
    hc(H/2);
    sda_low = 1'b1;
    hc(H/2);
    scl = 1'b1;
    hc(H);
    sda_low = 1'b0;
    hc(H);
  endtask
  // One bit; SDA moves only while SCL is low
  task automatic bt(input logic b, input logic own, output logic r);
    hc(H/2);
    drv     = own;
    sda_low = own & !b;
    hc(H/2);
    scl = 1'b1;
    hc(H/2);
    r = sda;
    hc(H/2);
    scl = 1'b0;
  endtask
  task automatic by(input logic [7:0] d, input logic wr, input logic ackv,
                    output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bt(d[i], wr, r[i]);
    bt(ackv, !wr, a);
  endtask
  // Short SCL pulse while SCL is low
  task automatic gl(input int n);
    scl = 1'b1;
    hc(n);
    scl = 1'b0;
  endtask
endmodule // idc_mst

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the converter code register
// Assumes: Own address default, master model on the bus
// Notes:   Line timing per the hand-over contract
`timescale 1ns/1ps
`include "idc_defs.svh"
module testbench;
  import idc_pkg::*;
  logic       mclk;
  logic       rst_b;
  logic       scl;
  logic       sda_low;
  logic       drv;
  logic       sda_out;
  logic       sda_oe;
  logic       out_valid;
  logic       hs_active;
  logic [9:0] dac_code;
  logic [1:0] pd_mode;
  logic [7:0] r;
  logic       k;
  wire        sda;
  int         fails;
  int         tests_run;
  assign sda = !(sda_low || (sda_oe && !sda_out));
  idc_code_reg u_idc_code_reg (.mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .dac_code(dac_code), .pd_mode(pd_mode),
    .out_valid(out_valid), .hs_active(hs_active));
  idc_mst u_idc_mst (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low), .drv(drv));
  always #5 mclk = ~mclk;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Device must not drive during master-owned bits
  always @(negedge scl) if (drv) chk(sda_oe, 1'b0);
  task automatic by(input logic [7:0] d, input logic wr, input logic ackv);
    u_idc_mst.by(d, wr, ackv, r, k);
  endtask
  task automatic idle(input int n);
    u_idc_mst.hc(n);
  endtask
  task automatic outs(input logic v, input logic [1:0] p, input logic [9:0] c);
    chk({3'h0, out_valid, pd_mode, dac_code}, {3'h0, v, p, c});
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] w, input logic ea);
    u_idc_mst.st();
    by({a, 1'b0}, 1, 1);
    chk(k, !ea);
    by(w[15:8], 1, 1);
    chk(k, !ea);
    by(w[7:0], 1, 1);
    chk(k, !ea);
    u_idc_mst.sp();
    idle(20);
  endtask
  task automatic rd(input logic [15:0] e);
    logic [7:0] hi;
    u_idc_mst.st();
    by({`IDC_OWN_ADDR_DEF, 1'b1}, 1, 1);
    chk(k, 1'b0);
    by(8'hff, 0, 0);
    hi = r;
    by(8'hff, 0, 1);
    chk({hi, r}, e);
    u_idc_mst.sp();
    idle(20);
  endtask
  task automatic t_reset();
    outs(0, 2'h0, 10'h000);
    chk(sda_oe, 1'b0);
  endtask
  // Lone byte must not update the output
  task automatic t_half();
    u_idc_mst.st();
    by({`IDC_OWN_ADDR_DEF, 1'b0}, 1, 1);
    by(8'h0f, 1, 1);
    u_idc_mst.sp();
    idle(20);
    outs(0, 2'h0, 10'h000);
  endtask
  task automatic t_full();
    wr(`IDC_OWN_ADDR_DEF, 16'h0ffc, 1);
    outs(1, 2'h0, 10'h3ff);
    rd(16'h0ffc);
  endtask
  task automatic t_pair();
    u_idc_mst.st();
    by({`IDC_OWN_ADDR_DEF, 1'b0}, 1, 1);
    by(8'h00, 1, 1);
    by(8'h04, 1, 1);
    idle(8);
    outs(1, 2'h0, 10'h001);
    by(8'h08, 1, 1);
    by(8'h00, 1, 1);
    u_idc_mst.sp();
    idle(20);
    outs(1, 2'h0, 10'h200);
  endtask
  task automatic t_other();
    wr(7'h0d, 16'h0554, 0);
    outs(1, 2'h0, 10'h200);
  endtask
  task automatic t_bcast();
    logic [15:0] w;
    for (int p = 0; p < 4; p++) begin
      w = {2'b00, p[1:0], 10'h155, 2'b00};
      wr(`IDC_BCAST_ADDR, w, 1);
      outs(1, p[1:0], 10'h155);
      rd(w);
    end
  endtask
  // 40 ns SCL spike inside a write must not clock a bit
  task automatic t_spike();
    u_idc_mst.st();
    by({`IDC_OWN_ADDR_DEF, 1'b0}, 1, 1);
    idle(12);
    u_idc_mst.gl(4);
    by(8'h00, 1, 1);
    by(8'h08, 1, 1);
    u_idc_mst.sp();
    idle(20);
    outs(1, 2'h0, 10'h002);
  endtask
  // Master code switches the filter to high speed until stop
  task automatic t_hs();
    u_idc_mst.st();
    by(8'h08, 1, 1);
    chk(k, 1'b1);
    u_idc_mst.st();
    chk(hs_active, 1'b1);
    by({`IDC_OWN_ADDR_DEF, 1'b0}, 1, 1);
    chk(k, 1'b0);
    by(8'h02, 1, 1);
    by(8'h00, 1, 1);
    u_idc_mst.sp();
    idle(20);
    chk(hs_active, 1'b0);
    outs(1, 2'h0, 10'h080);
  endtask
  initial begin
    mclk      = 1'b0;
    rst_b     = 1'b0;
    fails     = 0;
    tests_run = 0;
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    idle(4);
    t_reset();
    t_half();
    t_full();
    t_pair();
    t_other();
    t_bcast();
    t_spike();
    t_hs();
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge mclk);
    fails++;
    end_sim();
  end
endmodule // testbench
